// file: core/ics_defines.svh
`ifndef ICS_DEFINES_SVH
`define ICS_DEFINES_SVH

// Register offsets on the local port
`define ICS_OFS_CTRL2       8'h00
`define ICS_OFS_EN1         8'h02
`define ICS_OFS_PRIO24      8'h04
`define ICS_OFS_STATUS      8'h06
`define ICS_OFS_MASK        8'h08

// Control register two fields
`define ICS_ALT_BIT         15
`define ICS_TDIS_BIT        14
`define ICS_EP2_BIT         2
`define ICS_EP1_BIT         1
`define ICS_EP0_BIT         0

// Enable register one fields
`define ICS_EXT2_EN_BIT     13
`define ICS_EXT1_EN_BIT     4
`define ICS_CN_EN_BIT       3
`define ICS_AC1_EN_BIT      2
`define ICS_MI2C_EN_BIT     1
`define ICS_SI2C_EN_BIT     0
`define ICS_EN1_WMASK       16'h201f

// Priority register fields
`define ICS_PWM4_LSB        4
`define ICS_PWM3_LSB        0
`define ICS_PRIO24_WMASK    16'h0077

// Reset values
`define ICS_CTRL2_RST       16'h0000
`define ICS_EN1_RST         16'h0000
`define ICS_PRIO24_RST      16'h0044
`define ICS_STATUS_RST      9'h000
`define ICS_MASK_RST        9'h000

// Sources whose priority field lives outside this slice
`define ICS_FIXED_PRIO      3'h4

`endif

// file: core/ics_pkg.sv
package ics_pkg;

    localparam int ICS_NSRC = 9;

    typedef enum logic [3:0] {
        ICS_SRC_SI2C = 4'h0,
        ICS_SRC_MI2C = 4'h1,
        ICS_SRC_AC1  = 4'h2,
        ICS_SRC_CN   = 4'h3,
        ICS_SRC_EXT1 = 4'h4,
        ICS_SRC_EXT2 = 4'h5,
        ICS_SRC_EXT0 = 4'h6,
        ICS_SRC_PWM3 = 4'h7,
        ICS_SRC_PWM4 = 4'h8
    } ics_src_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] level;
        ics_src_t   id;
        logic       alt_table;
    } ics_core_req_t;

    typedef struct packed {
        logic       cn;
        logic       ac1;
        logic       mi2c;
        logic       si2c;
        logic       pwm3;
        logic       pwm4;
    } ics_periph_evt_t;

endpackage

// file: core/ics_edge_sync.sv
`timescale 1ns/10ps
module ics_edge_sync (
    input  wire logic i_core_clk,
    input  wire logic i_reset_n,
    input  wire logic i_pin,
    input  wire logic i_neg_edge,
    output logic      o_level,
    output logic      o_event
);
    logic [2:0] sync_r;
    logic       level_r;
    logic       event_r;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync_r <= 3'h0;
        end else begin
            sync_r <= {sync_r[1:0], i_pin};
        end
    end

    // Level only moves once the two later stages agree
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            level_r <= 1'b0;
            event_r <= 1'b0;
        end else begin
            event_r <= 1'b0;
            if (sync_r[2] == sync_r[1] && sync_r[2] != level_r) begin
                level_r <= sync_r[2];
                event_r <= (sync_r[2] != i_neg_edge);
            end
        end
    end

    assign o_level = level_r;
    assign o_event = event_r;
endmodule

// file: core/ics_top.sv
// Behaviour
// - Alternate-table bit 15 set selects alternate vectors, clear selects standard.
// - Bit 14 reads 1 while a timed interrupt-disable is active.
// - Per external pin polarity bit: 1 negative edge, 0 positive edge.
// - Unimplemented bits ignore writes and read as zero.
// - External interrupt 2 enable is enable register bit 13.
// - External interrupt 1 enable is enable register bit 4.
// - Change notification enable is enable register bit 3.
// - Comparator 1 enable is enable register bit 2.
// - I2C master enable bit 1, I2C slave enable bit 0.
// - Priority 1 to 7 direct, 7 highest, 0 disables source.
// - PWM 4 priority in bits 6..4, resets to 4.
// - PWM 3 priority in bits 2..0, resets to 4.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "ics_defines.svh"
module ics_top (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_reset_n,
    input  wire logic [7:0]               i_addr,
    input  wire logic [15:0]              i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic [15:0]                   o_rdata,
    input  wire logic [2:0]               i_ext_irq,
    input  wire ics_pkg::ics_periph_evt_t i_periph_evt,
    input  wire logic                     i_timed_disable,
    input  wire logic                     i_ack,
    input  wire ics_pkg::ics_src_t        i_ack_id,
    output ics_pkg::ics_core_req_t        o_core_req,
    output logic                          o_irq
);
    import ics_pkg::*;

    logic                alt_r;
    logic [2:0]          ep_r;
    logic [15:0]         en1_r;
    logic [15:0]         prio24_r;
    logic [ICS_NSRC-1:0] flags_r;
    logic [ICS_NSRC-1:0] status_r;
    logic [ICS_NSRC-1:0] mask_r;
    logic [15:0]         rdata_r;
    ics_core_req_t       req_r;
    logic                irq_r;
    logic [ICS_NSRC-1:0] qual_d_r;

    logic [2:0]          ext_evt;
    logic [2:0]          ext_lvl;
    logic [ICS_NSRC-1:0] evt;
    logic [ICS_NSRC-1:0] src_en;
    logic [ICS_NSRC-1:0] qual;
    logic [2:0]          lvl [ICS_NSRC];
    ics_core_req_t       req_nxt;
    logic [15:0]         rdata_nxt;
    logic                wr_ctrl2;
    logic                wr_en1;
    logic                wr_prio24;
    logic                wr_mask;
    logic                rd_status;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_ctrl2  = i_wr && hit(i_addr, `ICS_OFS_CTRL2);
    assign wr_en1    = i_wr && hit(i_addr, `ICS_OFS_EN1);
    assign wr_prio24 = i_wr && hit(i_addr, `ICS_OFS_PRIO24);
    assign wr_mask   = i_wr && hit(i_addr, `ICS_OFS_MASK);
    assign rd_status = i_rd && hit(i_addr, `ICS_OFS_STATUS);

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ext
            ics_edge_sync u_sync (
                .i_core_clk (i_core_clk),
                .i_reset_n  (i_reset_n),
                .i_pin      (i_ext_irq[g]),
                .i_neg_edge (ep_r[g]),
                .o_level    (ext_lvl[g]),
                .o_event    (ext_evt[g])
            );
        end
    endgenerate

    always_comb begin
        evt               = '0;
        evt[ICS_SRC_SI2C] = i_periph_evt.si2c;
        evt[ICS_SRC_MI2C] = i_periph_evt.mi2c;
        evt[ICS_SRC_AC1]  = i_periph_evt.ac1;
        evt[ICS_SRC_CN]   = i_periph_evt.cn;
        evt[ICS_SRC_EXT1] = ext_evt[1];
        evt[ICS_SRC_EXT2] = ext_evt[2];
        evt[ICS_SRC_EXT0] = ext_evt[0];
        evt[ICS_SRC_PWM3] = i_periph_evt.pwm3;
        evt[ICS_SRC_PWM4] = i_periph_evt.pwm4;
    end

    // Enables of ext0 and PWM live outside this slice, so treat them as set
    always_comb begin
        src_en               = '1;
        src_en[ICS_SRC_SI2C] = en1_r[`ICS_SI2C_EN_BIT];
        src_en[ICS_SRC_MI2C] = en1_r[`ICS_MI2C_EN_BIT];
        src_en[ICS_SRC_AC1]  = en1_r[`ICS_AC1_EN_BIT];
        src_en[ICS_SRC_CN]   = en1_r[`ICS_CN_EN_BIT];
        src_en[ICS_SRC_EXT1] = en1_r[`ICS_EXT1_EN_BIT];
        src_en[ICS_SRC_EXT2] = en1_r[`ICS_EXT2_EN_BIT];
    end

    always_comb begin
        for (int i = 0; i < ICS_NSRC; i++) begin
            lvl[i] = `ICS_FIXED_PRIO;
        end
        lvl[ICS_SRC_PWM4] = prio24_r[`ICS_PWM4_LSB +: 3];
        lvl[ICS_SRC_PWM3] = prio24_r[`ICS_PWM3_LSB +: 3];
    end

    always_comb begin
        for (int i = 0; i < ICS_NSRC; i++) begin
            qual[i] = flags_r[i] && src_en[i] && (lvl[i] != 3'h0);
        end
    end

    // highest level wins, lower id on a tie
    always_comb begin
        req_nxt           = '0;
        req_nxt.alt_table = alt_r;
        for (int i = 0; i < ICS_NSRC; i++) begin
            if (qual[i] && (!req_nxt.valid || lvl[i] > req_nxt.level)) begin
                req_nxt.valid = 1'b1;
                req_nxt.level = lvl[i];
                req_nxt.id    = ics_src_t'(i[3:0]);
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            alt_r <= 1'(`ICS_CTRL2_RST >> `ICS_ALT_BIT);
            ep_r  <= 3'(`ICS_CTRL2_RST & 16'h0007);
        end else if (wr_ctrl2) begin
            alt_r <= i_wdata[`ICS_ALT_BIT];
            ep_r  <= i_wdata[`ICS_EP2_BIT:`ICS_EP0_BIT];
        end
    end

    // write masks keep reserved bits zero
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            en1_r <= `ICS_EN1_RST;
        end else if (wr_en1) begin
            en1_r <= i_wdata & `ICS_EN1_WMASK;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prio24_r <= `ICS_PRIO24_RST;
        end else if (wr_prio24) begin
            prio24_r <= i_wdata & `ICS_PRIO24_WMASK;
        end
    end

    // Pending flags: the core's acknowledge clears, a fresh event wins
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags_r <= '0;
        end else begin
            for (int i = 0; i < ICS_NSRC; i++) begin
                if (evt[i]) begin
                    flags_r[i] <= 1'b1;
                end else if (i_ack && i_ack_id == ics_src_t'(i[3:0])) begin
                    flags_r[i] <= 1'b0;
                end
            end
        end
    end

    // Sticky status, cleared by reading it; a same-cycle event survives
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_r <= `ICS_STATUS_RST;
        end else begin
            status_r <= (rd_status ? '0 : status_r) | evt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask_r <= `ICS_MASK_RST;
        end else if (wr_mask) begin
            mask_r <= i_wdata[ICS_NSRC-1:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

    always_comb begin
        rdata_nxt = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `ICS_OFS_CTRL2: begin
                    rdata_nxt[`ICS_ALT_BIT]                = alt_r;
                    rdata_nxt[`ICS_TDIS_BIT]               = i_timed_disable;
                    rdata_nxt[`ICS_EP2_BIT:`ICS_EP0_BIT]   = ep_r;
                end
                `ICS_OFS_EN1: begin
                    rdata_nxt = en1_r;
                end
                `ICS_OFS_PRIO24: begin
                    rdata_nxt = prio24_r;
                end
                `ICS_OFS_STATUS: begin
                    rdata_nxt[ICS_NSRC-1:0] = status_r;
                end
                `ICS_OFS_MASK: begin
                    rdata_nxt[ICS_NSRC-1:0] = mask_r;
                end
                default: begin
                    rdata_nxt = 16'h0000;
                end
            endcase
        end
    end

    // Data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Registered request; one cycle behind flags and enables
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req_r <= '0;
        end else begin
            req_r <= req_nxt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            qual_d_r <= '0;
        end else begin
            qual_d_r <= qual;
        end
    end

    assign o_rdata    = rdata_r;
    assign o_core_req = req_r;
    assign o_irq      = irq_r;

    alt_vec_follow_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        wr_ctrl2 |=> ##1 (o_core_req.alt_table == $past(i_wdata[`ICS_ALT_BIT], 2)))
        else $error("alternate table select not followed");

    tdis_read_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_rd && hit(i_addr, `ICS_OFS_CTRL2))
            |=> (o_rdata[`ICS_TDIS_BIT] == $past(i_timed_disable)))
        else $error("timed disable status wrong");

    edge_dir_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        ext_evt[0] |-> (ext_lvl[0] == !$past(ep_r[0])))
        else $error("external edge of wrong polarity");

    ext_flag_set_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        ext_evt[2] |=> (flags_r[ICS_SRC_EXT2] && status_r[ICS_SRC_EXT2]))
        else $error("external edge did not raise flag");

    en1_reserved_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_rd && hit(i_addr, `ICS_OFS_EN1))
            |=> ((o_rdata & ~`ICS_EN1_WMASK) == 16'h0000))
        else $error("reserved enable bits read nonzero");

    ext2_gate_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (o_core_req.valid && o_core_req.id == ICS_SRC_EXT2)
            |-> $past(en1_r[`ICS_EXT2_EN_BIT]))
        else $error("ext2 presented while disabled");

    i2c_gate_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (o_core_req.valid && o_core_req.id == ICS_SRC_MI2C)
            |-> $past(en1_r[`ICS_MI2C_EN_BIT]))
        else $error("i2c master presented while disabled");

    prio_zero_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (o_core_req.valid && o_core_req.id == ICS_SRC_PWM3)
            |-> ($past(prio24_r[2:0]) != 3'h0))
        else $error("zero priority source presented");

    pwm4_level_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (o_core_req.valid && o_core_req.id == ICS_SRC_PWM4)
            |-> (o_core_req.level == $past(prio24_r[6:4])))
        else $error("pwm4 level mismatch");

    pwm3_write_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        wr_prio24 |=> ##1 (!o_core_req.valid || o_core_req.id != ICS_SRC_PWM3
            || o_core_req.level == $past(i_wdata[2:0], 2)))
        else $error("pwm3 priority write not applied");

    req_valid_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_core_req.valid == (qual_d_r != '0))
        else $error("request valid disagrees with pending sources");

    // Presented id must have been a qualified source
    req_qual_a: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_core_req.valid |-> qual_d_r[o_core_req.id])
        else $error("presented source was not pending and enabled");

endmodule

// file: test/ics_core_model.sv
`timescale 1ns/10ps
module ics_core_model (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset_n,
    input  wire ics_pkg::ics_core_req_t i_req,
    input  wire logic                   i_ack_en,
    output logic                        o_ack,
    output ics_pkg::ics_src_t           o_ack_id
);
    import ics_pkg::*;
    logic [1:0] wait_r;
    logic       hold_r;

    // Slow core: acknowledges after three valid cycles, then waits
    // for the acked source to leave so it is never acked twice
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_r   <= 2'h0;
            hold_r   <= 1'b0;
            o_ack    <= 1'b0;
            o_ack_id <= ICS_SRC_SI2C;
        end else begin
            o_ack <= 1'b0;
            if (hold_r) begin
                if (!i_req.valid || i_req.id != o_ack_id) begin
                    hold_r <= 1'b0;
                end
            end else if (i_req.valid && i_ack_en) begin
                wait_r <= wait_r + 2'h1;
                if (wait_r == 2'h2) begin
                    o_ack    <= 1'b1;
                    o_ack_id <= i_req.id;
                    hold_r   <= 1'b1;
                    wait_r   <= 2'h0;
                end
            end else begin
                wait_r <= 2'h0;
            end
        end
    end
endmodule

// file: test/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end
module tb;
    import ics_pkg::*;
    logic            i_core_clk, i_reset_n, i_wr, i_rd, i_timed_disable, i_ack, ack_en;
    logic [7:0]      i_addr;
    logic [15:0]     i_wdata, o_rdata, rv;
    logic [2:0]      i_ext_irq;
    ics_periph_evt_t i_periph_evt;
    ics_src_t        i_ack_id;
    ics_core_req_t   o_core_req;
    logic            o_irq;
    int              mismatches, total_checks;
    ics_src_t        xid [3] = '{ICS_SRC_EXT0, ICS_SRC_EXT1, ICS_SRC_EXT2};
    logic [15:0]     xen [3] = '{16'h0000, 16'h0010, 16'h2000};
    logic [7:0]      ofs [5] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0a};

    ics_top dut_u (.i_core_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_ext_irq, .i_periph_evt, .i_timed_disable, .i_ack, .i_ack_id, .o_core_req, .o_irq);
    ics_core_model core_u (.i_core_clk, .i_reset_n, .i_req(o_core_req), .i_ack_en(ack_en),
        .o_ack(i_ack), .o_ack_id(i_ack_id));

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        rv = o_rdata;
        `CHK(rv, e);
    endtask
    task automatic ev(input logic [5:0] v);
        @(posedge i_core_clk);
        i_periph_evt <= v;
        @(posedge i_core_clk);
        i_periph_evt <= '0;
    endtask
    // Pins move on a clock edge like every other input
    task automatic pin(input int p, input logic v);
        @(posedge i_core_clk);
        i_ext_irq[p] <= v;
    endtask
    task automatic qchk(input ics_src_t id, input logic [2:0] l, input logic alt);
        `CHK(o_core_req, {1'b1, l, id, alt});
    endtask
    // Bounded wait until the request line has stayed idle for three cycles in a row
    task automatic idle;
        int n;
        int q;
        n = 0;
        q = 0;
        while (q < 3 && n < 60) begin
            tick(1);
            q = (o_core_req.valid === 1'b0) ? q + 1 : 0;
            n++;
        end
        `CHK(q, 3);
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_core_clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        {i_reset_n, i_wr, i_rd, i_timed_disable, i_addr, i_wdata} = '0;
        i_ext_irq = 3'h0;
        i_periph_evt = '0;
        ack_en = 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        rchk(8'h00, 16'h0000); // control reset value
        rchk(8'h02, 16'h0000); // enables reset clear
        rchk(8'h04, 16'h0044); // priorities reset to four
        rchk(8'h08, 16'h0000); // mask reset clear
        rchk(8'h0a, 16'h0000); // unmapped reads zero
        foreach (ofs[i]) wr(ofs[i], 16'hffff);
        i_timed_disable <= 1'b1;
        rchk(8'h00, 16'hc007); // writable bits plus live disable status
        rchk(8'h02, 16'h201f); // enable bits
        rchk(8'h04, 16'h0077); // priority fields
        rchk(8'h08, 16'h01ff); // mask width only
        rchk(8'h0a, 16'h0000); // unmapped write ignored
        @(posedge i_core_clk);
        i_timed_disable <= 1'b0;
        rchk(8'h00, 16'h8007); // live disable status
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h0044);
        // Event while disabled is held back, then presented on enable
        for (int k = 0; k < 4; k++) begin
            wr(8'h02, 16'h0000);
            ev(6'h04 << k);
            tick(2);
            `CHK(o_core_req.valid, 1'b0); // blocked
            wr(8'h02, 16'h0001 << k);
            tick(1);
            qchk(ics_src_t'(k), 3'h4, 1'b0); // allowed
            idle(); // source drained
        end
        for (int p = 0; p < 3; p++) begin
            rchk(8'h06, (p == 0) ? 16'h000f : 16'h0000); // earlier events, read clears
            wr(8'h00, 16'h0001 << p);
            pin(p, 1'b1);
            tick(8);
            rchk(8'h06, 16'h0000); // rise ignored on negative polarity
            pin(p, 1'b0);
            tick(8);
            rchk(8'h06, 16'h1 << xid[p]); // falling edge caught
            tick(6);
            rchk(8'h06, 16'h0000); // one event per edge
            idle(); // request line idle; ext0 drained, ext1 and ext2 stay pending while disabled
            wr(8'h00, 16'h0000);
            wr(8'h02, 16'h0000);
            pin(p, 1'b1);
            tick(8);
            rchk(8'h06, 16'h1 << xid[p]); // rising edge caught
            if (p != 0) begin
                `CHK(o_core_req.valid, 1'b0); // blocked source
                wr(8'h02, xen[p]);
                tick(1);
                qchk(xid[p], 3'h4, 1'b0); // enabled source
            end
            idle(); // source drained
            pin(p, 1'b0);
            tick(8);
            rchk(8'h06, 16'h0000); // fall ignored on positive polarity
        end
        ack_en <= 1'b0;
        wr(8'h04, 16'h0071);
        ev(6'h03);
        tick(1);
        qchk(ICS_SRC_PWM4, 3'h7, 1'b0); // highest wins
        wr(8'h00, 16'h8000);
        tick(1);
        qchk(ICS_SRC_PWM4, 3'h7, 1'b1); // alternate table
        wr(8'h04, 16'h0001);
        tick(1);
        qchk(ICS_SRC_PWM3, 3'h1, 1'b1); // zero priority drops out
        for (int l = 2; l < 8; l++) begin
            wr(8'h04, 16'(l));
            tick(1);
            qchk(ICS_SRC_PWM3, 3'(l), 1'b1); // level follows field
        end
        wr(8'h04, 16'h0000);
        tick(1);
        `CHK(o_core_req.valid, 1'b0); // both disabled
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h0044);
        tick(1);
        qchk(ICS_SRC_PWM3, 3'h4, 1'b0); // tie goes to lower id
        ack_en <= 1'b1;
        idle(); // both drained
        rchk(8'h06, 16'h0180); // both events recorded
        wr(8'h08, 16'h0008);
        ev(6'h20);
        tick(1);
        `CHK(o_irq, 1'b1); // unmasked event raises line
        rchk(8'h06, 16'h0008); // read returns and clears
        tick(1);
        `CHK(o_irq, 1'b0); // line drops after clear
        ev(6'h10);
        tick(2);
        `CHK(o_irq, 1'b0); // masked event stays quiet
        rchk(8'h06, 16'h0004); // status still records it
        wrap_up();
    end
endmodule
